// >>> hw/rf_cfg_params.svh
// offsets, field positions, presets and timing of the transmitter configuration port
`ifndef RF_CFG_PARAMS_SVH
`define RF_CFG_PARAMS_SVH

// frame layout
`define RFC_FRAME_BITS      5'd24
`define RFC_CMD_BITS        5'd8
`define RFC_CMD_WR_APP      8'h00
`define RFC_CMD_RD_APP      8'h33
`define RFC_CMD_WR_FREQ_PFX 5'h03
`define RFC_CMD_RD_FREQ     8'h44
`define RFC_CMD_RD_STATUS   8'h55

// application register fields
`define RFC_APP_MODE        15
`define RFC_APP_MOD         14
`define RFC_APP_BAND        13
`define RFC_APP_DEV_HI      12
`define RFC_APP_DEV_LO      5
`define RFC_APP_PWR         4
`define RFC_APP_OFFT        3
`define RFC_APP_RSVD_VAL    3'h4

// power-on presets, low and high select level
`define RFC_APP_PRESET_LO   16'h201C
`define RFC_APP_PRESET_HI   16'h40D4
`define RFC_FREQ_PRESET_LO  19'h42C1C
`define RFC_FREQ_PRESET_HI  19'h42CAD

// timing
`define RFC_CLK_PERIOD_NS   25
`define RFC_WAKE_TIME_NS    50000
`define RFC_OFFT_SHORT_MS   2
`define RFC_OFFT_LONG_MS    20
`define RFC_BOOT_CYC        2'd3
`define RFC_HALF_CYC        3'd4

`endif

// >>> hw/rf_cfg_pkg.sv
// types shared by both ends of the transmitter configuration link
package rf_cfg_pkg;

  typedef enum logic [1:0] {DS_BOOT, DS_SLEEP, DS_TX} dev_state_e;

  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_REC} host_state_e;

  typedef enum logic [2:0] {
    OP_WR_APP, OP_RD_APP, OP_WR_FREQ, OP_RD_FREQ, OP_RD_STATUS, OP_RECOVER
  } host_op_e;

  typedef struct packed {
    logic [2:0]  ctrl_sync;
    logic [2:0]  data_sync;
    logic [1:0]  boot_cnt;
    dev_state_e  st;
    logic        preset_high;
    logic [15:0] app;
    logic [18:0] freq;
    logic [4:0]  bit_cnt;
    logic [23:0] shift;
    logic        rd_active;
    logic [15:0] out_sh;
    logic        data_o;
    logic        data_oe;
    logic [11:0] wake_cnt;
    logic [19:0] off_cnt;
    logic        tx;
    logic        carrier_on;
    logic        freq_shift;
  } dev_s;

  typedef struct packed {
    host_state_e st;
    logic [2:0]  div;
    logic [4:0]  bit_cnt;
    logic [23:0] frame;
    logic        is_read;
    host_op_e    op;
    logic [1:0]  rec_step;
    logic [1:0]  data_sync;
    logic [15:0] rdata;
    logic [15:0] freq_lo;
    logic [2:0]  freq_hi;
    logic        ctrl;
    logic        data_o;
    logic        data_oe;
    logic        busy;
    logic        done;
  } host_s;

endpackage

// >>> hw/rf_cfg_link_if.sv
// two-wire configuration link between host and transmitter
`timescale 1ns/1ps
`default_nettype none

interface rf_cfg_link_if;
  logic ctrl;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data;

  // weak pull-down when nobody drives
  assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b0);

  modport device (input ctrl, input data, output dev_data_o, output dev_data_oe);
  modport host (output ctrl, output host_data_o, output host_data_oe, input data);
endinterface

`default_nettype wire

// >>> hw/rf_cfg_device.sv
// transmitter end: serial configuration registers, presets and sleep/transmit control
//
// Functional notes
// - power-on samples control line, picks preset set
// - host keeps control line at power-on level
// - after preset, sleep while data low
// - each control rising edge captures one data bit
// - a transaction is exactly 24 rising edges
// - host accesses registers while asleep or transmitting
// - recovery pattern resynchronises the frame logic
// - three registers: application, frequency, status
// - command 00 writes, 33 reads application
// - 00011 writes frequency, 44 reads low sixteen
// - status read: version, state bits, frequency top
// - application register field layout
// - mode bit automatic/manual, resets to zero
// - modulation bit selects FSK or OOK
// - band bit, preset depends on select level
// - deviation field, high preset loads 0x06
// - power bit and off-time bit meaning
// - reserved low bits written and reset 100
// - frequency presets 0x42C1C and 0x42CAD
// - data high beyond wake interval starts transmit
// - automatic mode sleeps after data low off-time
// - manual mode transmits until mode bit cleared
`include "rf_cfg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rf_cfg_device #(
  parameter int         OFFT_SHORT_CYC =
    (`RFC_OFFT_SHORT_MS * 1000000 + `RFC_CLK_PERIOD_NS - 1) / `RFC_CLK_PERIOD_NS,
  parameter int         OFFT_LONG_CYC  =
    (`RFC_OFFT_LONG_MS * 1000000 + `RFC_CLK_PERIOD_NS - 1) / `RFC_CLK_PERIOD_NS,
  // arbitrary value
  parameter logic [7:0] CHIP_VERSION   = 8'h5A
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // two-wire link
  rf_cfg_link_if.device    link,
  // transmitter state
  output logic             o_tx_active,
  output logic             o_carrier_on,
  output logic             o_freq_shift,
  output logic             o_frame_busy,
  output logic             o_preset_high,
  // configuration towards the radio
  output logic             o_manual_mode,
  output logic             o_ook_mode,
  output logic             o_band_upper,
  output logic [7:0]       o_deviation,
  output logic             o_power_high,
  output logic             o_off_time_long,
  output logic [18:0]      o_carrier_frequency
);
  import rf_cfg_pkg::*;

  localparam int         WAKE_CYC_I = (`RFC_WAKE_TIME_NS + `RFC_CLK_PERIOD_NS - 1)
                                      / `RFC_CLK_PERIOD_NS;
  localparam logic [11:0] WAKE_CYC  = 12'(WAKE_CYC_I);
  localparam logic [19:0] OFFT_SHORT = 20'(OFFT_SHORT_CYC);
  localparam logic [19:0] OFFT_LONG  = 20'(OFFT_LONG_CYC);

  dev_s r;
  dev_s n;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        c_rise;
    logic        c_fall;
    logic        c_high;
    logic        d_in;
    logic        recover;
    logic [23:0] sh_new;
    logic [19:0] off_lim;
    logic [15:0] status_word;
    c_rise      = r.ctrl_sync[1] & ~r.ctrl_sync[2];
    c_fall      = ~r.ctrl_sync[1] & r.ctrl_sync[2];
    c_high      = r.ctrl_sync[2];
    d_in        = r.data_sync[2];
    // data moving while the control line stays high never happens in a frame
    recover     = (r.data_sync[1] ^ r.data_sync[2]) & r.ctrl_sync[1] & r.ctrl_sync[2]
                  & ~r.data_oe;
    sh_new      = {r.shift[22:0], d_in};
    off_lim     = r.app[`RFC_APP_OFFT] ? OFFT_LONG : OFFT_SHORT;
    status_word = {CHIP_VERSION, 3'h0, r.tx, 1'b0, r.freq[18:16]};

    n           = r;
    n.ctrl_sync = {r.ctrl_sync[1:0], link.ctrl};
    n.data_sync = {r.data_sync[1:0], link.data};

    // sleep / transmit control
    case (r.st)
      DS_BOOT: begin
        n.boot_cnt = r.boot_cnt + 2'd1;
        if (r.boot_cnt == `RFC_BOOT_CYC) begin
          n.preset_high = c_high;
          n.app         = c_high ? `RFC_APP_PRESET_HI : `RFC_APP_PRESET_LO;
          n.freq        = c_high ? `RFC_FREQ_PRESET_HI : `RFC_FREQ_PRESET_LO;
          n.st          = DS_SLEEP;
          n.wake_cnt    = 12'h000;
        end
      end
      DS_SLEEP: begin
        if (d_in && !c_rise && !c_fall && r.bit_cnt == 5'd0) begin
          n.wake_cnt = r.wake_cnt + 12'h001;
          if (r.wake_cnt > WAKE_CYC) begin
            n.st      = DS_TX;
            n.off_cnt = 20'h00000;
          end
        end else begin
          n.wake_cnt = 12'h000;
        end
      end
      DS_TX: begin
        if (d_in || r.app[`RFC_APP_MODE]) begin
          n.off_cnt = 20'h00000;
        end else begin
          n.off_cnt = r.off_cnt + 20'h00001;
          if (r.off_cnt > off_lim) begin
            n.st       = DS_SLEEP;
            n.wake_cnt = 12'h000;
          end
        end
      end
      default: begin
        n.st = DS_BOOT;
      end
    endcase

    // serial frame logic
    if (r.st != DS_BOOT) begin
      if (recover) begin
        n.bit_cnt   = 5'd0;
        n.rd_active = 1'b0;
        n.data_oe   = 1'b0;
      end else if (c_rise) begin
        n.shift   = sh_new;
        n.bit_cnt = r.bit_cnt + 5'd1;
        if (r.bit_cnt == `RFC_CMD_BITS - 5'd1) begin
          case (sh_new[7:0])
            `RFC_CMD_RD_APP: begin
              n.rd_active = 1'b1;
              n.out_sh    = r.app;
            end
            `RFC_CMD_RD_FREQ: begin
              n.rd_active = 1'b1;
              n.out_sh    = r.freq[15:0];
            end
            `RFC_CMD_RD_STATUS: begin
              n.rd_active = 1'b1;
              n.out_sh    = status_word;
            end
            default: begin
              n.rd_active = 1'b0;
            end
          endcase
        end
        if (r.bit_cnt == `RFC_FRAME_BITS - 5'd1) begin
          n.bit_cnt   = 5'd0;
          n.rd_active = 1'b0;
          n.data_oe   = 1'b0;
          if (sh_new[23:16] == `RFC_CMD_WR_APP) begin
            n.app = sh_new[15:0];
          end
          if (sh_new[23:19] == `RFC_CMD_WR_FREQ_PFX) begin
            n.freq = sh_new[18:0];
          end
        end
      end else if (c_fall && r.rd_active) begin
        n.data_oe = 1'b1;
        n.data_o  = r.out_sh[15];
        n.out_sh  = {r.out_sh[14:0], 1'b0};
      end
    end

    // keying of the carrier from the data line
    n.tx         = (n.st == DS_TX);
    n.carrier_on = n.tx && (n.app[`RFC_APP_MOD] ? d_in : 1'b1);
    n.freq_shift = n.tx && !n.app[`RFC_APP_MOD] && d_in;

    if (i_rst) begin
      n = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.dev_data_o  = r.data_o;
  assign link.dev_data_oe = r.data_oe;

  assign o_tx_active         = r.tx;
  assign o_carrier_on        = r.carrier_on;
  assign o_freq_shift        = r.freq_shift;
  assign o_frame_busy        = r.rd_active;
  assign o_preset_high       = r.preset_high;
  assign o_manual_mode       = r.app[`RFC_APP_MODE];
  assign o_ook_mode          = r.app[`RFC_APP_MOD];
  assign o_band_upper        = r.app[`RFC_APP_BAND];
  assign o_deviation         = r.app[`RFC_APP_DEV_HI:`RFC_APP_DEV_LO];
  assign o_power_high        = r.app[`RFC_APP_PWR];
  assign o_off_time_long     = r.app[`RFC_APP_OFFT];
  assign o_carrier_frequency = r.freq;

endmodule // rf_cfg_device

`default_nettype wire

// >>> hw/rf_cfg_host.sv
// host end: drives control clock and data, runs register frames and recovery
`include "rf_cfg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rf_cfg_host (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // request
  input  wire logic                i_start,
  input  wire rf_cfg_pkg::host_op_e i_op,
  input  wire logic [18:0]         i_wdata,
  // idle line levels
  input  wire logic                i_ctrl_idle,
  input  wire logic                i_tx_data,
  // answer
  output logic                     o_busy,
  output logic                     o_done,
  output logic [15:0]              o_rdata,
  output logic [18:0]              o_freq_full,
  // two-wire link
  rf_cfg_link_if.host              link
);
  import rf_cfg_pkg::*;

  host_s r;
  host_s n;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [23:0] frame;
    logic [15:0] rd_new;
    frame  = 24'h000000;
    rd_new = {r.rdata[14:0], r.data_sync[1]};
    case (i_op)
      OP_WR_APP:    frame = {`RFC_CMD_WR_APP, i_wdata[15:0]};
      OP_RD_APP:    frame = {`RFC_CMD_RD_APP, 16'h0000};
      OP_WR_FREQ:   frame = {`RFC_CMD_WR_FREQ_PFX, i_wdata};
      OP_RD_FREQ:   frame = {`RFC_CMD_RD_FREQ, 16'h0000};
      OP_RD_STATUS: frame = {`RFC_CMD_RD_STATUS, 16'h0000};
      default:      frame = 24'h000000;
    endcase

    n           = r;
    n.data_sync = {r.data_sync[0], link.data};
    n.done      = 1'b0;

    case (r.st)
      HS_IDLE: begin
        n.ctrl    = i_ctrl_idle;
        n.data_o  = i_tx_data;
        n.data_oe = 1'b1;
        if (i_start) begin
          n.busy     = 1'b1;
          n.op       = i_op;
          n.div      = 3'd0;
          n.bit_cnt  = 5'd0;
          n.rec_step = 2'd0;
          n.ctrl     = 1'b0;
          n.frame    = frame;
          n.data_o   = (i_op == OP_RECOVER) ? 1'b0 : frame[23];
          n.is_read  = (i_op == OP_RD_APP) || (i_op == OP_RD_FREQ) || (i_op == OP_RD_STATUS);
          n.st       = (i_op == OP_RECOVER) ? HS_REC : HS_LOW;
        end
      end
      HS_LOW: begin
        n.div = r.div + 3'd1;
        if (r.div == `RFC_HALF_CYC - 3'd1) begin
          n.div  = 3'd0;
          n.ctrl = 1'b1;
          n.st   = HS_HIGH;
        end
      end
      HS_HIGH: begin
        n.div = r.div + 3'd1;
        if (r.div == `RFC_HALF_CYC - 3'd1) begin
          n.div     = 3'd0;
          n.bit_cnt = r.bit_cnt + 5'd1;
          if (r.is_read && r.bit_cnt >= `RFC_CMD_BITS) begin
            n.rdata = rd_new;
          end
          if (r.bit_cnt == `RFC_FRAME_BITS - 5'd1) begin
            n.st      = HS_IDLE;
            n.busy    = 1'b0;
            n.done    = 1'b1;
            n.ctrl    = i_ctrl_idle;
            n.data_o  = i_tx_data;
            n.data_oe = 1'b1;
            if (r.op == OP_RD_FREQ) begin
              n.freq_lo = rd_new;
            end
            if (r.op == OP_RD_STATUS) begin
              n.freq_hi = rd_new[2:0];
            end
          end else begin
            n.ctrl    = 1'b0;
            n.frame   = {r.frame[22:0], 1'b0};
            n.data_o  = r.frame[22];
            n.data_oe = !(r.is_read && r.bit_cnt >= `RFC_CMD_BITS - 5'd1);
            n.st      = HS_LOW;
          end
        end
      end
      HS_REC: begin
        n.div = r.div + 3'd1;
        if (r.div == `RFC_HALF_CYC - 3'd1) begin
          n.div      = 3'd0;
          n.rec_step = r.rec_step + 2'd1;
          n.ctrl     = 1'b1;
          n.data_o   = (r.rec_step == 2'd1);
          if (r.rec_step == 2'd3) begin
            n.st     = HS_IDLE;
            n.busy   = 1'b0;
            n.done   = 1'b1;
            n.ctrl   = i_ctrl_idle;
            n.data_o = i_tx_data;
          end
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase

    if (i_rst) begin
      n      = '0;
      // control line keeps its power-on level through reset
      n.ctrl = i_ctrl_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.ctrl         = r.ctrl;
  assign link.host_data_o  = r.data_o;
  assign link.host_data_oe = r.data_oe;

  assign o_busy      = r.busy;
  assign o_done      = r.done;
  assign o_rdata     = r.rdata;
  assign o_freq_full = {r.freq_hi, r.freq_lo};

endmodule // rf_cfg_host

`default_nettype wire

// >>> test/rf_cfg_monitor.sv
// checker on the two-wire link between host and transmitter ends
`timescale 1ns/1ps
`default_nettype none

module rf_cfg_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link signals
  input wire logic ctrl,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [7:0] drive_cnt_r;

  // length of one read payload drive
  always_ff @(posedge i_clk) begin
    if (i_rst || !dev_data_oe) begin
      drive_cnt_r <= 8'h00;
    end else begin
      drive_cnt_r <= drive_cnt_r + 8'h01;
    end
  end

  a_no_contention: assert property (dev_data_oe |-> !host_data_oe)
    else $error("both ends drive data");
  a_ctrl_high_min: assert property ($rose(ctrl) |=> ctrl [*3])
    else $error("control high phase too short");
  a_ctrl_low_min: assert property ($fell(ctrl) |=> !ctrl [*3])
    else $error("control low phase too short");
  a_host_bit_setup: assert property ($rose(ctrl) && $past(host_data_oe) && host_data_oe
    |-> $stable(host_data_o))
    else $error("host data moved at control rise");
  a_dev_bit_hold: assert property (dev_data_oe && ctrl && $past(ctrl) |-> $stable(data))
    else $error("read bit moved while control high");
  a_drive_start: assert property ($rose(dev_data_oe) |-> !ctrl)
    else $error("device drive began in high phase");
  a_host_release: assert property ($fell(host_data_oe) |-> $fell(ctrl))
    else $error("host released data off control fall");
  a_drive_length: assert property ($fell(dev_data_oe) |-> drive_cnt_r inside {[8'h76:8'h82]})
    else $error("read payload drive not sixteen bits long");

  a_dev_drive_wins: assert property (dev_data_oe |-> data == dev_data_o)
    else $error("device drive not seen on data");
endmodule // rf_cfg_monitor

`default_nettype wire

// >>> test/rf_tx_config_serial_port_tb_top.sv
// testbench top: host and transmitter ends joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none

module rf_tx_config_serial_port_tb_top;
  import rf_cfg_pkg::*;

  // arbitrary value
  localparam logic [7:0] CHIP_VER = 8'h3C;

  logic        clk;
  logic        rst;
  logic        start;
  host_op_e    op;
  logic [18:0] wdata;
  logic        ctrl_idle;
  logic        tx_data;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  logic [18:0] freq_full;
  logic        tx_on;
  logic        carrier;
  logic        fshift;
  logic        manual;
  logic        ook;
  logic        band;
  logic [7:0]  dev;
  logic        pwr;
  logic        offt;
  logic        phigh;
  logic [18:0] freq;
  logic        fbusy;
  logic [18:0] tv [2];
  int          fails;
  int          n_checks;

  rf_cfg_link_if link ();

  rf_cfg_host i_rf_cfg_host (.i_clk(clk), .i_rst(rst), .i_start(start), .i_op(op),
    .i_wdata(wdata), .i_ctrl_idle(ctrl_idle), .i_tx_data(tx_data), .o_busy(busy),
    .o_done(done), .o_rdata(rdata), .o_freq_full(freq_full), .link(link));

  rf_cfg_device #(.OFFT_SHORT_CYC(20), .OFFT_LONG_CYC(40), .CHIP_VERSION(CHIP_VER))
    i_rf_cfg_device (.i_clk(clk), .i_rst(rst), .link(link), .o_tx_active(tx_on),
    .o_carrier_on(carrier), .o_freq_shift(fshift), .o_frame_busy(fbusy),
    .o_preset_high(phigh), .o_manual_mode(manual), .o_ook_mode(ook),
    .o_band_upper(band), .o_deviation(dev), .o_power_high(pwr),
    .o_off_time_long(offt), .o_carrier_frequency(freq));

  rf_cfg_monitor i_rf_cfg_monitor (.i_clk(clk), .i_rst(rst), .ctrl(link.ctrl),
    .host_data_o(link.host_data_o), .host_data_oe(link.host_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe), .data(link.data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(input logic lvl);
    ctrl_idle = lvl;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  // one host operation, bounded wait on its done pulse
  task automatic run(input host_op_e o, input logic [18:0] d);
    int k;
    @(negedge clk);
    op = o;
    wdata = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check(19'(busy), 19'h1);
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    check(19'({busy, done}), 19'h1);
    @(negedge clk);
  endtask

  task automatic rd(input host_op_e o, input logic [15:0] exp);
    run(o, 19'h0);
    check(19'(rdata), 19'(exp));
    check(19'(fbusy), 19'h0);
  endtask

  function automatic logic [18:0] app_out();
    return 19'({manual, ook, band, dev, pwr, offt, 3'h4});
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    start = 1'b0;
    op = OP_WR_APP;
    wdata = 19'h0;
    ctrl_idle = 1'b1;
    tx_data = 1'b0;
    fails = 0;
    n_checks = 0;
    tv = '{19'h00004, 19'h0400C};
    do_reset(1'b1);
    check(19'(phigh), 19'h1);
    check(app_out(), 19'h040D4);
    check(freq, 19'h42CAD);
    rd(OP_RD_APP, 16'h40D4);
    rd(OP_RD_FREQ, 16'h2CAD);
    rd(OP_RD_STATUS, {CHIP_VER, 5'h00, 3'h4});
    check(freq_full, 19'h42CAD);
    do_reset(1'b0);
    check(19'(phigh), 19'h0);
    check(app_out(), 19'h0201C);
    check(freq, 19'h42C1C);
    rd(OP_RD_APP, 16'h201C);
    run(OP_WR_APP, 19'h0B5AC);
    check(app_out(), 19'h0B5AC);
    run(OP_WR_FREQ, 19'h5A5A5);
    check(freq, 19'h5A5A5);
    rd(OP_RD_FREQ, 16'hA5A5);
    rd(OP_RD_STATUS, {CHIP_VER, 5'h00, 3'h5});
    check(freq_full, 19'h5A5A5);
    run(OP_RECOVER, 19'h0);
    rd(OP_RD_APP, 16'hB5AC);
    // automatic mode: FSK short off-time, then OOK long off-time
    for (int i = 0; i < 2; i++) begin
      run(OP_WR_APP, tv[i]);
      tx_data = 1'b1;
      repeat (1900) @(negedge clk);
      check(19'(tx_on), 19'h0);
      repeat (200) @(negedge clk);
      check(19'(tx_on), 19'h1);
      check(19'({carrier, fshift}), 19'(i == 0 ? 2'b11 : 2'b10));
      tx_data = 1'b0;
      repeat (5) @(negedge clk);
      check(19'({tx_on, carrier, fshift}), 19'(i == 0 ? 3'b110 : 3'b100));
      repeat (25) @(negedge clk);
      check(19'(tx_on), 19'(i));
      repeat (40) @(negedge clk);
      check(19'(tx_on), 19'h0);
    end
    // manual mode keeps sending until the mode bit is cleared
    run(OP_WR_APP, 19'h0C004);
    tx_data = 1'b1;
    repeat (2100) @(negedge clk);
    tx_data = 1'b0;
    repeat (300) @(negedge clk);
    check(19'(tx_on), 19'h1);
    rd(OP_RD_STATUS, {CHIP_VER, 5'h02, 3'h5});
    run(OP_WR_APP, 19'h04004);
    repeat (40) @(negedge clk);
    check(19'(tx_on), 19'h0);
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule // rf_tx_config_serial_port_tb_top

`default_nettype wire
